// ==== dv/tb.sv ====
// self-checking bench for the dual counter timer unit with a shadow copy of the storage registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk;
  logic sys_rst;
  logic [timer_unit_pkg::ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic measure_in;
  logic port_data;
  logic port_pin;
  logic byte_timer_output;
  logic wide_timer_output;
  logic irq;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed;
  int mreg [16];
  int per8 [$];
  int run8 = 0;
  int n;
  int v;
  logic last8 = 1'b0;
  logic [7:0] rd;
  logic [7:0] rd2;

  dual_counter_timer_unit dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .measure_in(measure_in),
    .port_data(port_data),
    .port_pin(port_pin),
    .byte_timer_output(byte_timer_output),
    .wide_timer_output(wide_timer_output),
    .irq(irq)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // length of each byte output level, queued at every change
  always @(posedge sys_clk)
  begin
    if (byte_timer_output !== last8) per8.push_back(run8);
    run8 <= (byte_timer_output !== last8) ? 1 : run8 + 1;
    last8 <= byte_timer_output;
  end

  // hang guard: the whole run needs well under this many cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic fail(input string msg);
    err_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask : chk

  // counts from the design may drift a cycle or two with pipeline depth
  task automatic chk_near(input logic [15:0] got, input int exp, input int tol, input string what);
    n_compared++;
    if (^got === 1'bx || int'(got) > exp + tol || int'(got) < exp - tol)
      fail($sformatf("%s got %0d expected %0d", what, got, exp));
  endtask : chk_near

  // one avalon transfer: held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [7:0] wd,
                     output logic [7:0] q);
    int t;
    t = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    do
    begin
      @(posedge sys_clk);
      t++;
    end
    while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (t >= 50) fail("bus answer lost");
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
    if (idx >= 4'h4 && idx <= 4'hB) mreg[idx] = d;
  endtask : wr

  task automatic rc(input logic [3:0] idx, input logic [7:0] e, input string what);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, e, what);
  endtask : rc

  // cycles until the chosen timer output changes level
  task automatic wait_tog(input logic wide, output int k);
    logic s;
    s = wide ? wide_timer_output : byte_timer_output;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while ((wide ? wide_timer_output : byte_timer_output) === s && k < 1200);
  endtask : wait_tog

  task automatic wait_q(input int k);
    int t;
    t = 0;
    while (per8.size() < k && t < 2000)
    begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 2000) fail("byte output stuck");
  endtask : wait_q

  initial
  begin
    seed = 32'hBFAFBF0C;
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    measure_in = 1'b0;
    port_data = 1'b0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset state, sync bit storage, plain storage and unmapped place
    rc(4'h3, 8'h00, "sync reset");
    wr(4'h3, 8'h20);
    rc(4'h3, 8'h20, "sync bit");
    for (int i = 4; i < 12; i++)
    begin
      v = $random(seed);
      wr(4'(i), v[7:0]);
    end
    for (int i = 4; i < 12; i++) rc(4'(i), mreg[i][7:0], "storage");
    wr(4'hE, 8'hA5);
    rc(4'hE, 8'h00, "unmapped");
    // ordinary pin follows port data one cycle late
    repeat (8)
    begin
      @(posedge sys_clk);
      v = port_data;
      port_data <= $random(seed);
      #1 chk({7'h0, port_pin}, {7'h0, v[0]}, "pin data");
    end
    port_data <= 1'b0;
    // byte single pass from high level, stopped mid-count and restarted
    n = 40 + ($random(seed) & 63);
    wr(4'h4, n[7:0]);
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h42);
    wr(4'hD, 8'h0F);
    wr(4'h3, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, byte_timer_output}, 8'h01, "initial level");
    rc(4'h3, 8'h40, "byte running");
    repeat (n / 2) @(posedge sys_clk);
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h40);
    wait_tog(1'b0, v);
    chk_near(v[15:0], n, 3, "restart pass");
    chk({7'h0, byte_timer_output}, 8'h00, "pass toggle");
    rc(4'h3, 8'h00, "pass halted");
    chk({7'h0, irq}, 8'h01, "pass irq");
    rc(4'hC, 8'h01, "pass status");
    // the clear lands on the edge that ends the read, so look one edge later
    @(posedge sys_clk);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    // modulo: first terminal silent, reload change only at next load, zero gives 256
    wr(4'h4, 8'd40);
    wr(4'h5, 8'd30);
    per8.delete();
    wr(4'h0, 8'h82);
    // low reload changed while its first low level runs: used only from the next load
    wait_q(2);
    rc(4'hC, 8'h00, "first terminal");
    wr(4'h5, 8'h00);
    wait_q(5);
    chk_near(per8[1][15:0], 40, 1, "first high period");
    chk_near(per8[2][15:0], 30, 1, "low period");
    chk_near(per8[3][15:0], 40, 1, "high period");
    chk_near(per8[4][15:0], 256, 1, "zero period");
    rc(4'hC, 8'h01, "modulo status");
    wr(4'h0, 8'h00);
    // wide single pass on the pin, timeout masked then unmasked
    n = 200 + ($random(seed) & 255);
    wr(4'h6, n[7:0]);
    wr(4'h7, n[15:8]);
    wr(4'h1, 8'h00);
    wr(4'hD, 8'h0B);
    wr(4'h2, 8'h43);
    wr(4'h3, 8'h80);
    wait_tog(1'b1, v);
    chk_near(v[15:0], n, 3, "wide pass");
    repeat (2) @(posedge sys_clk);
    chk({7'h0, port_pin}, 8'h01, "pin wide");
    chk({7'h0, irq}, 8'h00, "masked");
    rc(4'h2, 8'h63, "wide flag");
    wr(4'hD, 8'h0F);
    @(posedge sys_clk);
    chk({7'h0, irq}, 8'h01, "unmasked");
    rc(4'hC, 8'h04, "wide status");
    rc(4'h2, 8'h63, "flag kept");
    wr(4'h2, 8'h23);
    rc(4'h2, 8'h03, "flag cleared");
    // byte demodulation: high and low times, then wrap past zero
    wr(4'h5, 8'hFF);
    wr(4'h1, 8'h80);
    wr(4'h0, 8'h86);
    @(posedge sys_clk);
    measure_in <= 1'b1;
    repeat (90) @(posedge sys_clk);
    measure_in <= 1'b0;
    repeat (70) @(posedge sys_clk);
    measure_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    bus(1'b0, 4'hB, 8'h00, rd);
    chk_near({8'h00, rd}, 90, 2, "high time");
    bus(1'b0, 4'hA, 8'h00, rd);
    chk_near({8'h00, rd}, 70, 2, "low time");
    rc(4'hC, 8'h02, "edge status");
    repeat (300) @(posedge sys_clk);
    rc(4'hC, 8'h01, "demod wrap");
    wr(4'h0, 8'h00);
    // wide demodulation, first edge only
    wr(4'h6, 8'hFF);
    wr(4'h7, 8'hFF);
    wr(4'h2, 8'h94);
    repeat (300) @(posedge sys_clk);
    measure_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    bus(1'b0, 4'h9, 8'h00, rd);
    bus(1'b0, 4'h8, 8'h00, rd2);
    chk_near({rd, rd2}, 303, 4, "wide capture");
    rc(4'hC, 8'h08, "wide cap status");
    measure_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rc(4'h9, rd, "later edge high");
    rc(4'h8, rd2, "later edge low");
    rc(4'hC, 8'h00, "later edge status");
    wr(4'h2, 8'h00);
    // ping-pong: both stopped, single pass, field set, then byte started
    wr(4'h5, 8'd25);
    wr(4'h6, 8'd40);
    wr(4'h7, 8'h00);
    wr(4'h0, 8'h40);
    wr(4'h2, 8'h40);
    wr(4'h1, 8'h04);
    per8.delete();
    wr(4'h3, 8'h40);
    // byte high level spans the whole wide pass, the next low level the restarted byte pass
    wait_q(1);
    rc(4'h3, 8'h80, "wide running");
    wait_q(3);
    chk_near(per8[1][15:0], 40, 1, "wide handoff");
    chk_near(per8[2][15:0], 25, 1, "wide pass after");
    wr(4'h3, 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire

// ==== rtl/dual_counter_timer_unit.sv ====
// dual counter timer unit: 8-bit and 16-bit timers behind an avalon-mm slave
//
// Function
// R1: byte demod high capture holds high time
// R2: byte demod low capture holds low time
// R3: wide capture splits high and low bytes
// R4: wide edge mode: every edge or first only
// R5: wide timeout flag set, write one clears
// R6: wide capture raises interrupt when enabled
// R7: wide timeout raises interrupt when enabled
// R8: pin carries port data or wide output
// R9: sync register shows and sets run bits
// R10: byte start drives initial level, loads reload
// R11: byte single pass stops, toggles, flags timeout
// R12: byte modulo toggles, reloads, skips first flag
// R13: reload registers writable anytime, used next load
// R14: initial count zero gives 256 states
// R15: byte edges capture, flag, interrupt when enabled
// R16: byte demod reloads FF, wraps past zero
// R17: software stops, sets single pass, then starts
// R18: restart always reloads programmed value
// R19: ping-pong end of pass starts other timer
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module dual_counter_timer_unit (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [timer_unit_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic measure_in,
  input wire logic port_data,
  output logic port_pin,
  output logic byte_timer_output,
  output logic wide_timer_output,
  output logic irq
);

  typedef struct packed {
    logic t8_en;
    logic single8;
    logic to8;
    logic cap_ie8;
    logic to_ie8;
    logic demod;
    logic [1:0] pp;
    logic init8;
    logic init16;
    logic t16_en;
    logic single16;
    logic to16;
    logic edge16;
    logic cap_ie16;
    logic to_ie16;
    logic pin_sel;
    logic sync;
    logic [7:0] r8h;
    logic [7:0] r8l;
    logic [7:0] r16h;
    logic [7:0] r16l;
    logic [7:0] cap8h;
    logic [7:0] cap8l;
    logic [7:0] cap16h;
    logic [7:0] cap16l;
    logic [7:0] cnt8;
    logic [15:0] cnt16;
    logic out8;
    logic out16;
    logic first8;
    logic first16;
    logic lock16;
    logic [timer_unit_pkg::EV_W-1:0] ist;
    logic [timer_unit_pkg::EV_W-1:0] imask;
    logic meas_s1;
    logic meas_s2;
    logic meas_d;
    logic ack;
    logic [31:0] rdata;
    logic pin;
  } state_t;

  state_t st;
  state_t next_st;

  // reload value picked by the output level
  function automatic logic [7:0] pick_reload(input logic level, input logic [7:0] hi,
                                             input logic [7:0] lo);
    pick_reload = level ? hi : lo;
  endfunction : pick_reload

  // register read view
  function automatic logic [7:0] read_reg(input state_t s, input logic [3:0] idx);
    logic [7:0] r;
    r = timer_unit_pkg::BYTE_ZERO;
    unique case (idx)
      timer_unit_pkg::IDX_BYTE_CTRL:
      begin
        r[timer_unit_pkg::B_RUN] = s.t8_en;
        r[timer_unit_pkg::B_SINGLE] = s.single8;
        r[timer_unit_pkg::B_TIMEOUT] = s.to8;
        r[timer_unit_pkg::B_CAP_IE] = s.cap_ie8;
        r[timer_unit_pkg::B_TO_IE] = s.to_ie8;
      end
      timer_unit_pkg::IDX_SHARED_CTRL:
      begin
        r[timer_unit_pkg::S_DEMOD] = s.demod;
        r[timer_unit_pkg::S_PP_LSB +: 2] = s.pp;
        r[timer_unit_pkg::S_INIT8] = s.init8;
        r[timer_unit_pkg::S_INIT16] = s.init16;
      end
      timer_unit_pkg::IDX_WIDE_CTRL:
      begin
        r[timer_unit_pkg::B_RUN] = s.t16_en;
        r[timer_unit_pkg::B_SINGLE] = s.single16;
        r[timer_unit_pkg::B_TIMEOUT] = s.to16;
        r[timer_unit_pkg::W_EDGE_MODE] = s.edge16;
        r[timer_unit_pkg::B_CAP_IE] = s.cap_ie16;
        r[timer_unit_pkg::B_TO_IE] = s.to_ie16;
        r[timer_unit_pkg::W_PIN_SEL] = s.pin_sel;
      end
      timer_unit_pkg::IDX_SYNC_CTRL:
      begin
        r[timer_unit_pkg::Y_RUN16] = s.t16_en; // R9
        r[timer_unit_pkg::Y_RUN8] = s.t8_en; // R9
        r[timer_unit_pkg::Y_SYNC] = s.sync;
      end
      timer_unit_pkg::IDX_BYTE_RELOAD_HIGH: r = s.r8h;
      timer_unit_pkg::IDX_BYTE_RELOAD_LOW: r = s.r8l;
      timer_unit_pkg::IDX_WIDE_RELOAD_LOW: r = s.r16l;
      timer_unit_pkg::IDX_WIDE_RELOAD_HIGH: r = s.r16h;
      timer_unit_pkg::IDX_WIDE_CAP_LOW: r = s.cap16l;
      timer_unit_pkg::IDX_WIDE_CAP_HIGH: r = s.cap16h;
      timer_unit_pkg::IDX_BYTE_CAP_LOW: r = s.cap8l;
      timer_unit_pkg::IDX_BYTE_CAP_HIGH: r = s.cap8h;
      timer_unit_pkg::IDX_INT_STATUS: r[timer_unit_pkg::EV_W-1:0] = s.ist;
      timer_unit_pkg::IDX_INT_MASK: r[timer_unit_pkg::EV_W-1:0] = s.imask;
      default: r = timer_unit_pkg::BYTE_ZERO; // unmapped reads zero
    endcase
    read_reg = r;
  endfunction : read_reg

  logic [3:0] idx;
  logic wr;
  logic rd;
  logic rise;
  logic fall;
  logic tc8;
  logic tc16;
  logic cap8;
  logic cap16;

  // decode and events seen by the timers this cycle
  assign idx = avs_address[timer_unit_pkg::IDX_LSB +: 4];
  assign wr = avs_write && st.ack && avs_byteenable[0];
  assign rd = avs_read && st.ack;
  assign rise = st.meas_s2 && !st.meas_d;
  assign fall = !st.meas_s2 && st.meas_d;
  assign tc8 = st.t8_en && (st.cnt8 == timer_unit_pkg::CNT8_ONE);
  assign tc16 = st.t16_en && (st.cnt16 == timer_unit_pkg::CNT16_ONE);
  assign cap8 = st.demod && st.t8_en && (rise || fall);
  assign cap16 = st.demod && st.t16_en && (rise || fall) && !st.lock16;

  // one wait state per access, answer from flops
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign avs_readdata = st.rdata;
  assign byte_timer_output = st.out8;
  assign wide_timer_output = st.out16;
  assign port_pin = st.pin;
  assign irq = |(st.ist & st.imask);

  // next state: software first, then hardware events so a set beats a clear
  always_comb
  begin
    logic [7:0] wd;
    logic start8;
    logic start16;
    logic [timer_unit_pkg::EV_W-1:0] ev;
    wd = avs_writedata[7:0];
    start8 = 1'b0;
    start16 = 1'b0;
    ev = '0;
    next_st = st;
    next_st.meas_s1 = measure_in;
    next_st.meas_s2 = st.meas_s1;
    next_st.meas_d = st.meas_s2;
    next_st.ack = (avs_read || avs_write) && !st.ack;
    next_st.rdata = {24'h000000, read_reg(st, idx)};
    // read of status clears only the bits it reported
    if (rd && idx == timer_unit_pkg::IDX_INT_STATUS)
    begin
      next_st.ist = st.ist & ~st.rdata[timer_unit_pkg::EV_W-1:0];
    end
    if (wr)
    begin
      unique case (idx)
        timer_unit_pkg::IDX_BYTE_CTRL:
        begin
          start8 = wd[timer_unit_pkg::B_RUN] && !st.t8_en;
          next_st.t8_en = wd[timer_unit_pkg::B_RUN];
          next_st.single8 = wd[timer_unit_pkg::B_SINGLE];
          if (wd[timer_unit_pkg::B_TIMEOUT])
          begin
            next_st.to8 = 1'b0;
          end
          next_st.cap_ie8 = wd[timer_unit_pkg::B_CAP_IE];
          next_st.to_ie8 = wd[timer_unit_pkg::B_TO_IE];
        end
        timer_unit_pkg::IDX_SHARED_CTRL:
        begin
          next_st.demod = wd[timer_unit_pkg::S_DEMOD];
          next_st.pp = wd[timer_unit_pkg::S_PP_LSB +: 2];
          next_st.init8 = wd[timer_unit_pkg::S_INIT8];
          next_st.init16 = wd[timer_unit_pkg::S_INIT16];
        end
        timer_unit_pkg::IDX_WIDE_CTRL:
        begin
          start16 = wd[timer_unit_pkg::B_RUN] && !st.t16_en;
          next_st.t16_en = wd[timer_unit_pkg::B_RUN];
          next_st.single16 = wd[timer_unit_pkg::B_SINGLE];
          if (wd[timer_unit_pkg::B_TIMEOUT])
          begin
            next_st.to16 = 1'b0; // R5
          end
          next_st.edge16 = wd[timer_unit_pkg::W_EDGE_MODE];
          next_st.cap_ie16 = wd[timer_unit_pkg::B_CAP_IE];
          next_st.to_ie16 = wd[timer_unit_pkg::B_TO_IE];
          next_st.pin_sel = wd[timer_unit_pkg::W_PIN_SEL];
        end
        timer_unit_pkg::IDX_SYNC_CTRL:
        begin
          // R9
          start16 = wd[timer_unit_pkg::Y_RUN16] && !st.t16_en;
          start8 = wd[timer_unit_pkg::Y_RUN8] && !st.t8_en;
          next_st.t16_en = wd[timer_unit_pkg::Y_RUN16];
          next_st.t8_en = wd[timer_unit_pkg::Y_RUN8];
          next_st.sync = wd[timer_unit_pkg::Y_SYNC];
        end
        // reloads take effect only at the next load
        timer_unit_pkg::IDX_BYTE_RELOAD_HIGH: next_st.r8h = wd; // R13
        timer_unit_pkg::IDX_BYTE_RELOAD_LOW: next_st.r8l = wd; // R13
        timer_unit_pkg::IDX_WIDE_RELOAD_LOW: next_st.r16l = wd;
        timer_unit_pkg::IDX_WIDE_RELOAD_HIGH: next_st.r16h = wd;
        timer_unit_pkg::IDX_WIDE_CAP_LOW: next_st.cap16l = wd;
        timer_unit_pkg::IDX_WIDE_CAP_HIGH: next_st.cap16h = wd;
        timer_unit_pkg::IDX_BYTE_CAP_LOW: next_st.cap8l = wd;
        timer_unit_pkg::IDX_BYTE_CAP_HIGH: next_st.cap8h = wd;
        timer_unit_pkg::IDX_INT_MASK: next_st.imask = wd[timer_unit_pkg::EV_W-1:0];
        default: next_st.sync = next_st.sync; // unmapped writes ignored
      endcase
    end
    // byte timer
    if (st.t8_en && st.demod)
    begin
      // decrement wraps 00 to FF, so a timeout never stops it
      next_st.cnt8 = st.cnt8 - timer_unit_pkg::CNT8_ONE; // R16
      if (cap8)
      begin
        if (fall)
        begin
          next_st.cap8h = timer_unit_pkg::CNT8_FULL - st.cnt8; // R1 R15
        end
        else
        begin
          next_st.cap8l = timer_unit_pkg::CNT8_FULL - st.cnt8; // R2 R15
        end
        next_st.cnt8 = timer_unit_pkg::CNT8_FULL; // R16
        ev[timer_unit_pkg::EV_T8_CAP] = st.cap_ie8; // R15
      end
      else if (tc8)
      begin
        next_st.to8 = 1'b1; // R16
        ev[timer_unit_pkg::EV_T8_TO] = st.to_ie8;
      end
    end
    else if (st.t8_en)
    begin
      // count 1 is terminal, so a load of 0 runs 256 states
      next_st.cnt8 = st.cnt8 - timer_unit_pkg::CNT8_ONE; // R14
      if (tc8)
      begin
        next_st.out8 = !st.out8; // R11 R12
        if (st.single8)
        begin
          next_st.t8_en = 1'b0; // R11
          next_st.to8 = 1'b1;
          ev[timer_unit_pkg::EV_T8_TO] = st.to_ie8;
          start16 = start16 || (st.pp == timer_unit_pkg::PP_ON); // R19
        end
        else
        begin
          next_st.cnt8 = pick_reload(!st.out8, st.r8h, st.r8l); // R12
          next_st.first8 = 1'b0;
          if (!st.first8)
          begin
            next_st.to8 = 1'b1; // R12
            ev[timer_unit_pkg::EV_T8_TO] = st.to_ie8;
          end
        end
      end
    end
    // wide timer
    if (st.t16_en && st.demod)
    begin
      next_st.cnt16 = st.cnt16 - timer_unit_pkg::CNT16_ONE;
      if (cap16)
      begin
        {next_st.cap16h, next_st.cap16l} = timer_unit_pkg::CNT16_FULL - st.cnt16; // R3
        next_st.cnt16 = timer_unit_pkg::CNT16_FULL;
        next_st.lock16 = st.edge16; // R4
        ev[timer_unit_pkg::EV_T16_CAP] = st.cap_ie16; // R6
      end
      else if (tc16)
      begin
        next_st.to16 = 1'b1; // R5
        ev[timer_unit_pkg::EV_T16_TO] = st.to_ie16; // R7
      end
    end
    else if (st.t16_en)
    begin
      next_st.cnt16 = st.cnt16 - timer_unit_pkg::CNT16_ONE;
      if (tc16)
      begin
        next_st.out16 = !st.out16;
        if (st.single16)
        begin
          next_st.t16_en = 1'b0;
          next_st.to16 = 1'b1; // R5
          ev[timer_unit_pkg::EV_T16_TO] = st.to_ie16; // R7
          start8 = start8 || (st.pp == timer_unit_pkg::PP_ON); // R19
        end
        else
        begin
          next_st.cnt16 = {st.r16h, st.r16l};
          next_st.first16 = 1'b0;
          if (!st.first16)
          begin
            next_st.to16 = 1'b1; // R5
            ev[timer_unit_pkg::EV_T16_TO] = st.to_ie16; // R7
          end
        end
      end
    end
    // a start always reloads, so a stale count is never reused
    if (start8)
    begin
      next_st.t8_en = 1'b1;
      next_st.out8 = next_st.init8; // R10
      next_st.cnt8 = pick_reload(next_st.init8, next_st.r8h, next_st.r8l); // R10 R18
      next_st.first8 = 1'b1;
    end
    if (start16)
    begin
      next_st.t16_en = 1'b1;
      next_st.out16 = next_st.init16;
      next_st.cnt16 = {next_st.r16h, next_st.r16l}; // R18
      next_st.first16 = 1'b1;
      next_st.lock16 = 1'b0;
    end
    next_st.ist = next_st.ist | ev;
    next_st.pin = next_st.pin_sel ? next_st.out16 : port_data; // R8
  end

  // single state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_bus_one_wait: assert property (
    (avs_read || avs_write) && !st.ack |=> st.ack ##1 !st.ack)
    else $error("access not answered after one wait state");
  a_cap8_high_time: assert property ( // R1
    cap8 && fall && !(wr && idx == timer_unit_pkg::IDX_BYTE_CAP_HIGH)
    |=> st.cap8h == timer_unit_pkg::CNT8_FULL - $past(st.cnt8)
        && st.cnt8 == timer_unit_pkg::CNT8_FULL)
    else $error("byte high capture wrong");
  a_cap8_low_time: assert property ( // R2
    cap8 && rise |=> st.cap8l == timer_unit_pkg::CNT8_FULL - $past(st.cnt8))
    else $error("byte low capture wrong");
  a_cap16_bytes: assert property ( // R3
    cap16 |=> {st.cap16h, st.cap16l} == timer_unit_pkg::CNT16_FULL - $past(st.cnt16))
    else $error("wide capture bytes wrong");
  a_edge16_lock: assert property ( // R4
    cap16 && st.edge16 |=> !cap16 [*2])
    else $error("wide capture after first edge in edge mode");
  // a capture in demod and the first modulo terminal raise no timeout
  a_to16_sticky: assert property ( // R5
    tc16 && !cap16 && (st.demod || st.single16 || !st.first16)
    |=> st.to16 ##1 (st.to16 || $past(wr && idx == timer_unit_pkg::IDX_WIDE_CTRL)))
    else $error("wide timeout flag not held");
  a_to16_irq: assert property ( // R7
    tc16 && st.to_ie16 && st.imask[timer_unit_pkg::EV_T16_TO] && !st.demod
    && (st.single16 || !st.first16) && !(wr && idx == timer_unit_pkg::IDX_INT_MASK)
    |=> irq)
    else $error("wide timeout gave no interrupt");
  a_start8_load: assert property ( // R10
    wr && idx == timer_unit_pkg::IDX_BYTE_CTRL && avs_writedata[timer_unit_pkg::B_RUN]
    && !st.t8_en |=> st.out8 == st.init8
    && st.cnt8 == (st.init8 ? st.r8h : st.r8l))
    else $error("byte start level or load wrong");
  a_single8_halt: assert property ( // R11
    tc8 && st.single8 && !st.demod && !wr |=> !st.t8_en && st.to8
    && st.out8 != $past(st.out8))
    else $error("byte single pass did not halt");
  a_pingpong_hand: assert property ( // R19
    tc8 && st.single8 && !st.demod && st.pp == timer_unit_pkg::PP_ON |=> st.t16_en)
    else $error("ping-pong did not start wide timer");

endmodule : dual_counter_timer_unit
`default_nettype wire

// ==== rtl/timer_unit_pkg.sv ====
// constants shared by the dual counter timer unit
package timer_unit_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_BYTE_CTRL = 4'h0;
  localparam logic [3:0] IDX_SHARED_CTRL = 4'h1;
  localparam logic [3:0] IDX_WIDE_CTRL = 4'h2;
  localparam logic [3:0] IDX_SYNC_CTRL = 4'h3;
  localparam logic [3:0] IDX_BYTE_RELOAD_HIGH = 4'h4;
  localparam logic [3:0] IDX_BYTE_RELOAD_LOW = 4'h5;
  localparam logic [3:0] IDX_WIDE_RELOAD_LOW = 4'h6;
  localparam logic [3:0] IDX_WIDE_RELOAD_HIGH = 4'h7;
  localparam logic [3:0] IDX_WIDE_CAP_LOW = 4'h8;
  localparam logic [3:0] IDX_WIDE_CAP_HIGH = 4'h9;
  localparam logic [3:0] IDX_BYTE_CAP_LOW = 4'hA;
  localparam logic [3:0] IDX_BYTE_CAP_HIGH = 4'hB;
  localparam logic [3:0] IDX_INT_STATUS = 4'hC;
  localparam logic [3:0] IDX_INT_MASK = 4'hD;
  localparam int ADDR_W = 6;
  localparam int IDX_LSB = 2;
  // byte timer control fields
  localparam int B_RUN = 7;
  localparam int B_SINGLE = 6;
  localparam int B_TIMEOUT = 5;
  localparam int B_CAP_IE = 2;
  localparam int B_TO_IE = 1;
  // shared control fields
  localparam int S_DEMOD = 7;
  localparam int S_PP_LSB = 2;
  localparam int S_INIT8 = 1;
  localparam int S_INIT16 = 0;
  localparam logic [1:0] PP_ON = 2'h1;
  // wide timer control fields
  localparam int W_EDGE_MODE = 4;
  localparam int W_PIN_SEL = 0;
  // sync control fields
  localparam int Y_RUN16 = 7;
  localparam int Y_RUN8 = 6;
  localparam int Y_SYNC = 5;
  // interrupt status and mask bits
  localparam int EV_T8_TO = 0;
  localparam int EV_T8_CAP = 1;
  localparam int EV_T16_TO = 2;
  localparam int EV_T16_CAP = 3;
  localparam int EV_W = 4;
  // counter values
  localparam logic [7:0] CNT8_ONE = 8'h01;
  localparam logic [7:0] CNT8_FULL = 8'hFF;
  localparam logic [15:0] CNT16_ONE = 16'h0001;
  localparam logic [15:0] CNT16_FULL = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : timer_unit_pkg
